// ---- common/cpu_status_defines.vh ----
// Purpose: register map and field positions of the cpu status block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   offsets for status, control and interrupt registers are chosen
`ifndef CPU_STATUS_DEFINES_VH
`define CPU_STATUS_DEFINES_VH

// apb byte offsets
`define OFS_STATUS      8'h00
`define OFS_CONTROL     8'h04
`define OFS_INT_CTL_ONE 8'h08
`define OFS_EFF_PRIO    8'h0C
`define OFS_IRQ_STATUS  8'h10
`define OFS_IRQ_MASK    8'h14

// status word field positions
`define SR_CARRY        0
`define SR_ZERO         1
`define SR_WRAP         2
`define SR_NEG          3
`define SR_REPEAT       4
`define SR_PRIO_LO      5
`define SR_PRIO_HI      7
`define SR_NIBBLE       8

// control word field positions
`define CC_PRIO_TOP     3
`define CC_DATA_SAT     5
`define CC_DEPTH_LO     8
`define CC_DEPTH_HI     10
`define CC_EARLY_TERM   11
`define CC_UNSIGNED     12
`define CC_RESET        16'h0020
`define CC_WRITE_MASK   16'h18FF

// interrupt control one
`define IC1_NEST_DIS    15

// interrupt event bits
`define EV_PRIO_CHANGE  0
`define EV_WRAP         1
`define EV_WRITE_DROP   2
`define EV_WIDTH        3

`define PRIO_MASK_ALL   3'h7
`endif

// ---- rtl/alu_flag_calc.v ----
// Purpose: compute condition flags of one alu result
// Assumes: operands and raw sum come from the datapath in the same cycle
// Notes:   purely combinational
`timescale 1ns/100ps
`default_nettype none
module alu_flag_calc (
  // operation
  input  wire        byte_op,
  input  wire [15:0] op_a,
  input  wire [15:0] op_b,
  input  wire [15:0] result,
  input  wire        carry_out,
  input  wire        nibble_carry_in,
  // flags
  output wire        nibble_carry,
  output wire        negative,
  output wire        wrap,
  output wire        zero,
  output wire        carry
);
  // sign bits depend on operand size
  wire sa = byte_op ? op_a[7] : op_a[15];
  wire sb = byte_op ? op_b[7] : op_b[15];
  wire sr = byte_op ? result[7] : result[15];

  // datapath supplies the carry out of bit 3 or 7 itself
  assign nibble_carry = nibble_carry_in;
  assign negative     = sr;
  // like signs in, other sign out: the sign changed wrongly
  assign wrap  = (sa == sb) && (sr != sa);
  assign zero  = byte_op ? (result[7:0] == 8'h00)
                         : (result == 16'h0000);
  assign carry = carry_out;
endmodule // alu_flag_calc
`default_nettype wire

// ---- rtl/irq_gather.v ----
// Purpose: sticky event bits, mask and one level interrupt
// Assumes: clear by writing one; a new event wins over its clear
// Notes:   width is a parameter
`timescale 1ns/100ps
`default_nettype none
module irq_gather #(
  parameter W = 3
) (
  // clock and reset
  input  wire         sys_clk,
  input  wire         rst,
  // events and software
  input  wire [W-1:0] event_in,
  input  wire [W-1:0] clear_in,
  input  wire [W-1:0] mask,
  // results
  output reg  [W-1:0] sticky,
  output wire         irq
);
  // set wins over clear so an event in the clear cycle survives
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sticky <= {W{1'b0}};
    end else begin
      sticky <= (sticky & ~clear_in) | event_in;
    end
  end

  assign irq = |(sticky & mask);
endmodule // irq_gather
`default_nettype wire

// ---- rtl/cpu_status_bank.v ----
// Purpose: cpu status word and core control word with apb access
// Assumes: datapath strobes one update per cycle; apb answers at once
// Notes:   accumulator and loop flags of the upper status byte omitted
`timescale 1ns/100ps
`default_nettype none
`include "cpu_status_defines.vh"

module cpu_status_bank (
  // clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // alu update from the datapath
  input  wire        alu_valid,
  input  wire        alu_byte,
  input  wire [15:0] alu_op_a,
  input  wire [15:0] alu_op_b,
  input  wire [15:0] alu_result,
  input  wire        alu_carry_out,
  input  wire        alu_nibble_out,
  input  wire [4:0]  alu_affect,
  // loop state from the sequencer
  input  wire        repeat_running,
  input  wire [2:0]  loop_depth,
  // priority access by interrupt logic
  input  wire        prio_load,
  input  wire [3:0]  prio_load_value,
  // outputs to the core
  output wire [15:0] cpu_status_word,
  output wire [15:0] core_control_word,
  output wire [3:0]  effective_priority,
  output wire        user_irq_blocked,
  output wire        unsigned_multiply_select,
  output wire        early_loop_terminate,
  output wire        data_write_saturate,
  output wire        irq
);
  // flag registers
  reg        nibble_carry_flag;
  reg  [2:0] cpu_priority_level;
  reg        negative_flag;
  reg        signed_wrap_flag;
  reg        zero_flag;
  reg        carry_flag;
  reg  [15:0] ctl;
  reg  [15:0] interrupt_ctl_one;
  reg  [`EV_WIDTH-1:0] irq_mask;

  wire [`EV_WIDTH-1:0] irq_sticky;
  wire       f_nib;
  wire       f_neg;
  wire       f_wrap;
  wire       f_zero;
  wire       f_carry;

  // apb decode: zero wait states, every access completes
  wire wr = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  wire wr_status = wr && hit(paddr, `OFS_STATUS);
  wire wr_ctl    = wr && hit(paddr, `OFS_CONTROL);
  wire wr_ic1    = wr && hit(paddr, `OFS_INT_CTL_ONE);
  wire wr_isr    = wr && hit(paddr, `OFS_IRQ_STATUS);
  wire wr_imask  = wr && hit(paddr, `OFS_IRQ_MASK);
  wire nest_dis  = interrupt_ctl_one[`IC1_NEST_DIS];

  alu_flag_calc u_calc (
    .byte_op         (alu_byte),
    .op_a            (alu_op_a),
    .op_b            (alu_op_b),
    .result          (alu_result),
    .carry_out       (alu_carry_out),
    .nibble_carry_in (alu_nibble_out),
    .nibble_carry    (f_nib),
    .negative        (f_neg),
    .wrap            (f_wrap),
    .zero            (f_zero),
    .carry           (f_carry)
  );

  // condition flags; datapath update has priority over a software write
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      nibble_carry_flag <= 1'b0;
      negative_flag     <= 1'b0;
      signed_wrap_flag  <= 1'b0;
      zero_flag         <= 1'b0;
      carry_flag        <= 1'b0;
    end else if (alu_valid) begin
      // only the flags this instruction affects may move
      if (alu_affect[4])
        nibble_carry_flag <= f_nib;
      if (alu_affect[3])
        negative_flag <= f_neg;
      if (alu_affect[2])
        signed_wrap_flag <= f_wrap;
      // zero flag follows the result: set on zero result, cleared by non-zero
      if (alu_affect[1])
        zero_flag <= f_zero;
      if (alu_affect[0])
        carry_flag <= f_carry;
    end else if (wr_status) begin
      nibble_carry_flag <= pwdata[`SR_NIBBLE];
      negative_flag     <= pwdata[`SR_NEG];
      signed_wrap_flag  <= pwdata[`SR_WRAP];
      zero_flag         <= pwdata[`SR_ZERO];
      carry_flag        <= pwdata[`SR_CARRY];
    end
  end

  // priority level: interrupt logic load beats software write
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cpu_priority_level <= 3'h0;
    end else if (prio_load) begin
      cpu_priority_level <= prio_load_value[2:0];
    end else if (wr_status && !nest_dis) begin
      // locked against software while nesting is disabled
      cpu_priority_level <= pwdata[`SR_PRIO_HI:`SR_PRIO_LO];
    end
  end

  // control word; top priority bit may be cleared by software only
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctl <= `CC_RESET;
    end else begin
      if (wr_ctl)
        ctl <= (pwdata[15:0] & `CC_WRITE_MASK) |
               (ctl & ~`CC_WRITE_MASK);
      if (wr_ctl && !pwdata[`CC_PRIO_TOP])
        ctl[`CC_PRIO_TOP] <= 1'b0;
      else if (wr_ctl)
        ctl[`CC_PRIO_TOP] <= ctl[`CC_PRIO_TOP];
      if (prio_load)
        ctl[`CC_PRIO_TOP] <= prio_load_value[3];
    end
  end

  // interrupt control one and event mask
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      interrupt_ctl_one <= 16'h0000;
      irq_mask          <= {`EV_WIDTH{1'b0}};
    end else begin
      if (wr_ic1)
        interrupt_ctl_one <= pwdata[15:0];
      if (wr_imask)
        irq_mask <= pwdata[`EV_WIDTH-1:0];
    end
  end

  // events: priority change, signed wrap, refused priority write
  wire [`EV_WIDTH-1:0] events;
  assign events[`EV_PRIO_CHANGE] = prio_load;
  assign events[`EV_WRAP]        = alu_valid && alu_affect[2] && f_wrap;
  assign events[`EV_WRITE_DROP]  = wr_status && nest_dis && !prio_load &&
         (pwdata[`SR_PRIO_HI:`SR_PRIO_LO] != cpu_priority_level);

  irq_gather #(.W(`EV_WIDTH)) u_irq (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .event_in (events),
    .clear_in (wr_isr ? pwdata[`EV_WIDTH-1:0] : {`EV_WIDTH{1'b0}}),
    .mask     (irq_mask),
    .sticky   (irq_sticky),
    .irq      (irq)
  );

  // assembled words; loop depth and repeat flag follow the sequencer
  assign cpu_status_word = {7'h00, nibble_carry_flag, cpu_priority_level,
                            repeat_running,
                            negative_flag, signed_wrap_flag,
                            zero_flag, carry_flag};
  assign core_control_word = {ctl[15:11], loop_depth,
                              ctl[7:0]};
  assign effective_priority = {ctl[`CC_PRIO_TOP],
                               cpu_priority_level};
  // top bit or level seven shuts out user interrupts
  assign user_irq_blocked = ctl[`CC_PRIO_TOP] ||
                            (cpu_priority_level == `PRIO_MASK_ALL);
  assign unsigned_multiply_select = ctl[`CC_UNSIGNED];
  assign early_loop_terminate     = ctl[`CC_EARLY_TERM];
  assign data_write_saturate      = ctl[`CC_DATA_SAT];

  // read data registered in the setup cycle, valid in the access phase
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `OFS_STATUS:      prdata <= {16'h0000, cpu_status_word};
        `OFS_CONTROL:     prdata <= {16'h0000, core_control_word};
        `OFS_INT_CTL_ONE: prdata <= {16'h0000, interrupt_ctl_one};
        `OFS_EFF_PRIO:    prdata <= {28'h0000000, effective_priority};
        `OFS_IRQ_STATUS:  prdata <= {29'h00000000, irq_sticky};
        `OFS_IRQ_MASK:    prdata <= {29'h00000000, irq_mask};
        default:          prdata <= 32'h00000000;
      endcase
    end
  end
endmodule // cpu_status_bank
`default_nettype wire

// ---- test/alu_model.sv ----
// Purpose: datapath stand-in issuing one add to the status block
// Assumes: op is called right after a rising edge of sys_clk
// Notes:   adds only, so signed wrap follows operand and sum signs
`timescale 1ns/100ps
`default_nettype none
module alu_model (
  // clock
  input  wire logic        sys_clk,
  // update towards the status block
  output var  logic        alu_valid,
  output var  logic        alu_byte,
  output var  logic [15:0] alu_op_a,
  output var  logic [15:0] alu_op_b,
  output var  logic [15:0] alu_result,
  output var  logic        alu_carry_out,
  output var  logic        alu_nibble_out,
  output var  logic [4:0]  alu_affect
);
  // quiet datapath until the first update
  initial begin
    {alu_valid, alu_byte, alu_op_a, alu_op_b, alu_result} = '0;
    {alu_carry_out, alu_nibble_out, alu_affect} = '0;
  end

  // one-cycle strobe; the spare edge keeps two strobes apart
  task op(input logic [15:0] a, input logic [15:0] b, input logic byt,
          input logic [4:0] aff);
    logic [16:0] s;
    logic [8:0]  h;
    begin
      s = byt ? {9'h000, a[7:0]} + {9'h000, b[7:0]} : {1'b0, a} + {1'b0, b};
      h = byt ? {5'h00, a[3:0]} + {5'h00, b[3:0]}
              : {1'b0, a[7:0]} + {1'b0, b[7:0]};
      alu_valid      <= 1'b1;
      alu_byte       <= byt;
      alu_op_a       <= a;
      alu_op_b       <= b;
      alu_result     <= byt ? {a[15:8], s[7:0]} : s[15:0];
      alu_carry_out  <= byt ? s[8] : s[16];
      alu_nibble_out <= byt ? h[4] : h[8];
      alu_affect     <= aff;
      @(posedge sys_clk);
      alu_valid <= 1'b0;
      @(posedge sys_clk);
    end
  endtask
endmodule // alu_model
`default_nettype wire

// ---- test/cpu_status_bank_properties.sv ----
// Purpose: port-level checks of the status and control words
// Assumes: one clock domain, reset disables every check
// Notes:   byte updates judge sign and zero on the low byte
`timescale 1ns/100ps
`default_nettype none
module cpu_status_bank_check (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // apb and datapath
  input wire logic        psel,
  input wire logic        pwrite,
  input wire logic        alu_valid,
  input wire logic        alu_byte,
  input wire logic [15:0] alu_op_a,
  input wire logic [15:0] alu_op_b,
  input wire logic [15:0] alu_result,
  input wire logic        alu_carry_out,
  input wire logic        alu_nibble_out,
  input wire logic [4:0]  alu_affect,
  input wire logic        repeat_running,
  // core side
  input wire logic [15:0] cpu_status_word,
  input wire logic [15:0] core_control_word,
  input wire logic [3:0]  effective_priority,
  input wire logic        user_irq_blocked
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // sign and zero of the operand size in use
  wire sr = alu_byte ? alu_result[7] : alu_result[15];
  wire sa = alu_byte ? alu_op_a[7] : alu_op_a[15];
  wire sb = alu_byte ? alu_op_b[7] : alu_op_b[15];
  wire ovf = (sa == sb) && (sr != sa);
  wire zr = alu_byte ? alu_result[7:0] == 8'h00 : alu_result == 16'h0000;
  AST_DC: assert property (alu_valid && alu_affect[4] |=>
    cpu_status_word[8] == $past(alu_nibble_out)) else $error("dc flag");
  AST_BLK: assert property (user_irq_blocked ==
    (core_control_word[3] || cpu_status_word[7:5] == 3'h7))
    else $error("block");
  AST_EFF: assert property (effective_priority ==
    {core_control_word[3], cpu_status_word[7:5]}) else $error("eff prio");
  AST_RA: assert property (cpu_status_word[4] == repeat_running)
    else $error("repeat flag");
  AST_NEG: assert property (alu_valid && alu_affect[3] |=>
    cpu_status_word[3] == $past(sr)) else $error("neg flag");
  AST_OV: assert property (alu_valid && alu_affect[2] |=>
    cpu_status_word[2] == $past(ovf)) else $error("wrap flag");
  AST_Z: assert property (alu_valid && alu_affect[1] |=>
    cpu_status_word[1] == $past(zr)) else $error("zero flag");
  AST_C: assert property (alu_valid && alu_affect[0] |=>
    cpu_status_word[0] == $past(alu_carry_out)) else $error("carry");
  AST_KEEP: assert property (alu_valid && !alu_affect[1] &&
    !(psel && pwrite) |=> $stable(cpu_status_word[1])) else $error("keep");
endmodule // cpu_status_bank_check
bind cpu_status_bank cpu_status_bank_check u_check (.sys_clk, .rst, .psel,
  .pwrite, .alu_valid, .alu_byte, .alu_op_a, .alu_op_b, .alu_result,
  .alu_carry_out, .alu_nibble_out, .alu_affect, .repeat_running,
  .cpu_status_word, .core_control_word, .effective_priority,
  .user_irq_blocked);
`default_nettype wire

// ---- test/tb_cpu_status_bank.sv ----
// Purpose: apb-driven checks of the status and control block
// Assumes: zero-wait apb slave, flags fed by the datapath model
// Notes:   a spare idle edge follows every transfer
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_status_bank;
  logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, repeat_running = 1'b0, prio_load = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic [2:0] loop_depth = 3'h0;
  logic [3:0] prio_load_value = 4'h0;
  wire pready, pslverr, alu_valid, alu_byte, alu_carry_out, alu_nibble_out;
  wire user_irq_blocked, unsigned_multiply_select, irq;
  wire early_loop_terminate, data_write_saturate;
  wire [31:0] prdata;
  wire [15:0] alu_op_a, alu_op_b, alu_result;
  wire [15:0] cpu_status_word, core_control_word;
  wire [4:0] alu_affect;
  wire [3:0] effective_priority;
  integer miscompares = 0, tests_run = 0, i;
  logic [15:0] ta [5] = '{16'h7FFF, 16'hFFFF, 16'h0001, 16'h000F, 16'h0080};
  logic [15:0] tv [5] = '{16'h0001, 16'h0001, 16'h0002, 16'h0001, 16'h0080};
  logic [15:0] te [5] = '{16'h010C, 16'h0103, 16'h0000, 16'h0100, 16'h0007};
  logic [4:0] tby = 5'b11000;

  always #4 sys_clk = ~sys_clk;

  cpu_status_bank u_dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .alu_valid, .alu_byte, .alu_op_a,
    .alu_op_b, .alu_result, .alu_carry_out, .alu_nibble_out, .alu_affect,
    .repeat_running, .loop_depth, .prio_load, .prio_load_value,
    .cpu_status_word, .core_control_word, .effective_priority,
    .user_irq_blocked, .unsigned_multiply_select, .early_loop_terminate,
    .data_write_saturate, .irq);
  alu_model u_alu (.sys_clk, .alu_valid, .alu_byte, .alu_op_a, .alu_op_b,
    .alu_result, .alu_carry_out, .alu_nibble_out, .alu_affect);

  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // setup, then access until pready; release only after that edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer n;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge sys_clk);
        n = n + 1;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
        miscompares = miscompares + 1;
        print_verdict;
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
    end
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
      // every read must complete without an error response
      chk({31'h0, pslverr}, 32'h0);
    end
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rdc(8'h04, 32'h0000_0020);
    rdc(8'h1C, 32'h0);
    loop_depth <= 3'h3;
    apb(1'b1, 8'h04, 32'h0000_18FF);
    rdc(8'h04, 32'h0000_1BF7);
    chk({29'h0, unsigned_multiply_select, early_loop_terminate,
      data_write_saturate}, 32'h7);
    $display("control test done");
    for (i = 0; i < 5; i++) begin
      u_alu.op(ta[i], tv[i], tby[i], 5'h1F);
      rdc(8'h00, {16'h0, te[i]});
    end
    u_alu.op(16'h0001, 16'h0001, 1'b0, 5'h01);
    rdc(8'h00, 32'h6);
    repeat_running <= 1'b1;
    apb(1'b1, 8'h00, 32'h0);
    rdc(8'h00, 32'h10);
    repeat_running <= 1'b0;
    apb(1'b1, 8'h00, 32'h10);
    rdc(8'h00, 32'h0);
    $display("flag test done");
    apb(1'b1, 8'h00, 32'hE0);
    chk({31'h0, user_irq_blocked}, 32'h1);
    apb(1'b1, 8'h00, 32'hA0);
    rdc(8'h0C, 32'h5);
    chk({31'h0, user_irq_blocked}, 32'h0);
    prio_load <= 1'b1;
    prio_load_value <= 4'hA;
    @(posedge sys_clk);
    prio_load <= 1'b0;
    @(posedge sys_clk);
    rdc(8'h0C, 32'hA);
    chk({31'h0, user_irq_blocked, irq}, 32'h2);
    rdc(8'h10, 32'h3); // wrap events of the flag test are still pending
    apb(1'b1, 8'h04, 32'h0);
    rdc(8'h04, 32'h0300);
    $display("priority test done");
    apb(1'b1, 8'h14, 32'h4);
    rdc(8'h14, 32'h4);
    apb(1'b1, 8'h10, 32'h1);
    apb(1'b1, 8'h08, 32'h8000);
    rdc(8'h08, 32'h8000);
    apb(1'b1, 8'h00, 32'hE0);
    rdc(8'h00, 32'h40);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 8'h10, 32'h4);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h00, 32'hE0);
    rdc(8'h00, 32'hE0);
    $display("nesting test done");
    print_verdict;
  end
endmodule // tb_cpu_status_bank
`default_nettype wire
